// ===== core/iefc_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Source event always sets its request flag
// [RULE_02] Flag vectors only with its own enable
// [RULE_03] Global enable low blocks every interrupt
// [RULE_04] Entry pushes next instruction address
// [RULE_05] Program counter then loads the vector
// [RULE_06] Return instruction pops saved program counter
// [RULE_07] Taking an interrupt clears global enable
// [RULE_08] Flags still latch while in service
// [RULE_09] Full stack holds off every acknowledgement
// [RULE_10] Software re-enables global bit for nesting
// [RULE_11] Own vectors plus shared multi-function vectors
// [RULE_12] Second control register bit layout
// [RULE_13] Smallest variant third register: timebase only
// [RULE_14] Full third register layout, twelve-key subset
// [RULE_15] Fourth register exists in largest variant
// [RULE_16] Multi-function register: two counter flag pairs
// [RULE_17] Third multi-function register for modules four/five
// [RULE_18] Software preserves reserved multi-function bits
// [RULE_19] Unimplemented bits ignore writes, read zero
// [RULE_20] Shared vector clears only multi-function flag
// [RULE_21] Any set flag wakes the device
// [RULE_22] Own-vector service clears its flag
// [RULE_23] Lowest vector address wins among pending
// [RULE_24] Flags and enables reset to zero
module iefc_ctrl
  import iefc_pkg::*;
#(
  parameter int VARIANT = 3
)
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [11:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Peripheral events
  input  wire iefc_evt_s        evt_i,
  // Program sequencer side
  input  wire logic             boundary_i,
  input  wire logic [PC_W-1:0]  next_pc_i,
  input  wire logic             stack_full_i,
  input  wire logic             return_from_irq_instr_i,
  input  wire logic [PC_W-1:0]  ret_addr_i,
  output iefc_jump_s            jump_o,
  output logic                  wake_o
);

  if (VARIANT < 0 || VARIANT > 3)
  begin : g_bad_variant
    $error("iefc_ctrl: VARIANT must be 0 to 3");
  end

  iefc_state_s          s_q;
  iefc_state_s          s_d;
  logic [NSRC-1:0]      src_evt;
  logic [NSRC-1:0]      req_act;
  logic [NMF-1:0]       mf_evt;
  logic                 pick_any;
  logic [SRC_W-1:0]     pick_idx;
  logic                 take;
  logic                 mapped;
  logic [IDX_W-1:0]     widx;
  logic                 any_flag;
  logic [NREG-1:0][7:0] set_v;
  logic [NREG-1:0][7:0] clr_v;
  logic [NSRC-1:0]      flag_vec;
  logic [NSRC-1:0]      en_vec;
  logic                 apb_wr;

  // Any software write this cycle, used to qualify the checks
  assign apb_wr = psel_i && penable_i && pwrite_i;

  // Address decode: word aligned, eight words
  assign mapped = (paddr_i[11:5] == 7'h00) && (paddr_i[1:0] == 2'b00);
  assign widx   = paddr_i[4:2];

  // A group raises its shared flag when an enabled member fires
  for (genvar g = 0; g < NMF; g++)
  begin : g_mf
    assign mf_evt[g] = (evt_i.touch_cnt[2*g] & s_q.regs[REG_MF_ZERO+g][CNT_EVEN_EBIT])
                     | (evt_i.touch_cnt[2*g+1] & s_q.regs[REG_MF_ZERO+g][CNT_ODD_EBIT]); // RULE_11
  end

  // Event per source, in priority order
  assign src_evt = {evt_i.touch[5], evt_i.touch[4], mf_evt[2], evt_i.timer_one,
                    evt_i.touch[3], evt_i.touch[2], mf_evt[1], evt_i.timebase,
                    mf_evt[0], evt_i.timer_zero, evt_i.eeprom, evt_i.serial_if};

  // Flag gated by its own enable
  for (genvar i = 0; i < NSRC; i++)
  begin : g_src
    assign flag_vec[i] = s_q.regs[SRC_REG[i]][SRC_FBIT[i]];
    assign en_vec[i]   = s_q.regs[SRC_REG[i]][SRC_EBIT[i]];
    assign req_act[i]  = flag_vec[i] & en_vec[i]; // RULE_02
  end

  iefc_prio_pick #(
    .N      (NSRC)
  ) u_pick (
    .req_i  (req_act),
    .any_o  (pick_any),
    .idx_o  (pick_idx)
  );

  // Entry needs the global bit, room on the stack and an idle sequencer
  assign take = (s_q.phase == PH_IDLE) && boundary_i && !return_from_irq_instr_i && pick_any
              && s_q.regs[REG_GLOBAL][GLOBAL_EN_BIT]  // RULE_03
              && !stack_full_i;                       // RULE_09

  // Flags only; enables and reserved bits do not wake
  always_comb
  begin
    any_flag = 1'b0;
    for (int i = 0; i < NSRC; i++)
    begin
      any_flag = any_flag | s_q.regs[SRC_REG[i]][SRC_FBIT[i]];
    end
    for (int g = 0; g < NMF; g++)
    begin
      any_flag = any_flag | s_q.regs[REG_MF_ZERO+g][CNT_EVEN_FBIT] | s_q.regs[REG_MF_ZERO+g][CNT_ODD_FBIT];
    end
  end

  // Next-state logic
  always_comb
  begin
    s_d   = s_q;
    set_v = '0;
    clr_v = '0;

    // Hardware sets, regardless of each flag's own enable or service state
    for (int i = 0; i < NSRC; i++)
    begin
      set_v[SRC_REG[i]][SRC_FBIT[i]] = src_evt[i]; // RULE_01 RULE_08
    end
    for (int g = 0; g < NMF; g++)
    begin
      set_v[REG_MF_ZERO+g][CNT_EVEN_FBIT] = evt_i.touch_cnt[2*g];   // RULE_16 RULE_17
      set_v[REG_MF_ZERO+g][CNT_ODD_FBIT]  = evt_i.touch_cnt[2*g+1]; // RULE_16 RULE_17
    end

    // Sequencer handshake; a return beats a new entry
    s_d.phase = PH_IDLE;
    if (return_from_irq_instr_i)
    begin
      s_d.phase   = PH_RETURN;
      s_d.pc_addr = ret_addr_i; // RULE_06
    end
    else if (take)
    begin
      s_d.phase    = PH_ENTER;
      s_d.push_pc  = next_pc_i;          // RULE_04
      s_d.pc_addr  = vec_addr(pick_idx); // RULE_05 RULE_23
      s_d.last_src = pick_idx;
      // Only the vectored flag clears; member flags of a group stay
      clr_v[SRC_REG[pick_idx]][SRC_FBIT[pick_idx]] = 1'b1; // RULE_20 RULE_22
      clr_v[REG_GLOBAL][GLOBAL_EN_BIT]             = 1'b1; // RULE_07
    end

    // Write, then hardware clear, then set; set wins over any clear
    for (int r = 0; r < NREG; r++)
    begin
      if (psel_i && penable_i && pwrite_i && mapped && (widx == IDX_W'(r)))
      begin
        s_d.regs[r] = pwdata_i[7:0];
      end
      s_d.regs[r] = ((s_d.regs[r] & ~clr_v[r]) | set_v[r]) & impl_mask(VARIANT, r); // RULE_19 RULE_12 RULE_13 RULE_14 RULE_15
    end

    // Read data captured in the setup cycle
    if (psel_i && !penable_i)
    begin
      s_d.prdata = 32'h0000_0000;
      if (mapped && !pwrite_i)
      begin
        if (widx == IDX_W'(REG_STATUS))
        begin
          s_d.prdata[STAT_WAKE_BIT]   = any_flag;
          s_d.prdata[SRC_W-1:0]       = s_q.last_src;
        end
        else
        begin
          s_d.prdata[7:0] = s_q.regs[widx] & impl_mask(VARIANT, int'(widx)); // RULE_19
        end
      end
    end
  end

  // State register; everything clears on reset
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_q.regs     <= {NREG{REG_RESET}}; // RULE_24
      s_q.phase    <= PH_IDLE;
      s_q.push_pc  <= '0;
      s_q.pc_addr  <= '0;
      s_q.last_src <= '0;
      s_q.prdata   <= 32'h0000_0000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave; unmapped words answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o  = s_q.prdata;

  // Sequencer requests stand for one cycle
  assign jump_o.push    = (s_q.phase == PH_ENTER);
  assign jump_o.pop     = (s_q.phase == PH_RETURN);
  assign jump_o.pc_load = (s_q.phase != PH_IDLE);
  assign jump_o.push_pc = s_q.push_pc;
  assign jump_o.pc_addr = s_q.pc_addr;
  assign wake_o         = any_flag; // RULE_21

  // Checks
  property p_evt_sets_flag;
    @(posedge clk_i) disable iff (srst_i)
    evt_i.timer_zero |=> s_q.regs[REG_CTRL_ONE][7];
  endproperty
  a_evt_sets_flag: assert property (p_evt_sets_flag) else $error("event did not set flag"); // RULE_01

  property p_global_blocks;
    @(posedge clk_i) disable iff (srst_i)
    !s_q.regs[REG_GLOBAL][GLOBAL_EN_BIT] |=> !jump_o.push;
  endproperty
  a_global_blocks: assert property (p_global_blocks) else $error("entry with global disabled"); // RULE_03

  property p_full_blocks;
    @(posedge clk_i) disable iff (srst_i)
    stack_full_i |=> !jump_o.push;
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("entry with stack full"); // RULE_09

  property p_push_pc;
    @(posedge clk_i) disable iff (srst_i)
    jump_o.push |-> (jump_o.push_pc == $past(next_pc_i)) && jump_o.pc_load;
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed wrong return address"); // RULE_04

  property p_vector;
    @(posedge clk_i) disable iff (srst_i)
    jump_o.push |-> jump_o.pc_addr == vec_addr($past(pick_idx));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector loaded"); // RULE_05

  property p_global_cleared;
    @(posedge clk_i) disable iff (srst_i)
    take |=> !s_q.regs[REG_GLOBAL][GLOBAL_EN_BIT] && jump_o.push ##1 !jump_o.push;
  endproperty
  a_global_cleared: assert property (p_global_cleared) else $error("global enable kept on entry"); // RULE_07

  property p_return;
    @(posedge clk_i) disable iff (srst_i)
    return_from_irq_instr_i |=> jump_o.pop && jump_o.pc_load && (jump_o.pc_addr == $past(ret_addr_i));
  endproperty
  a_return: assert property (p_return) else $error("return did not restore address"); // RULE_06

  property p_wake;
    @(posedge clk_i) disable iff (srst_i)
    (evt_i.timebase && VARIANT >= 0) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("flag did not wake"); // RULE_21

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (srst_i)
    (psel_i && !penable_i && !pwrite_i && mapped && widx == IDX_W'(REG_CTRL_THR) && VARIANT != 3)
      |=> prdata_o == 32'h0000_0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented register read nonzero"); // RULE_19

  // A flag with its enable low must never lead to an entry
  property p_enable_gate;
    @(posedge clk_i) disable iff (srst_i)
    ((flag_vec & en_vec) == '0) |=> !jump_o.push;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("entry without enabled flag"); // RULE_02

  // No lower-numbered enabled request may be pending when one is taken
  property p_prio;
    @(posedge clk_i) disable iff (srst_i)
    take |-> ((flag_vec & en_vec) & ((NSRC'(1) << pick_idx) - NSRC'(1))) == '0;
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority request taken first"); // RULE_23

  // Serviced flag clears unless a fresh event lands in the same cycle
  property p_own_clears;
    @(posedge clk_i) disable iff (srst_i)
    (take && !src_evt[pick_idx]) |=> !flag_vec[$past(pick_idx)];
  endproperty
  a_own_clears: assert property (p_own_clears) else $error("serviced flag not cleared"); // RULE_22

  // Group member flag survives service of its shared vector
  property p_member_kept;
    @(posedge clk_i) disable iff (srst_i)
    (take && pick_idx == SRC_W'(3) && s_q.regs[REG_MF_ZERO][CNT_EVEN_FBIT] && !apb_wr)
      |=> s_q.regs[REG_MF_ZERO][CNT_EVEN_FBIT];
  endproperty
  a_member_kept: assert property (p_member_kept) else $error("member flag cleared by service"); // RULE_20

  // With global low no entry happens, so flags only accumulate
  property p_flag_held;
    @(posedge clk_i) disable iff (srst_i)
    (!s_q.regs[REG_GLOBAL][GLOBAL_EN_BIT] && !apb_wr) |=> (flag_vec & $past(flag_vec)) == $past(flag_vec);
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("pending flag lost"); // RULE_08

  // Enabled member event raises the shared group flag
  property p_mf_set;
    @(posedge clk_i) disable iff (srst_i)
    (evt_i.touch_cnt[0] && s_q.regs[REG_MF_ZERO][CNT_EVEN_EBIT]) |=> s_q.regs[REG_CTRL_ONE][6];
  endproperty
  a_mf_set: assert property (p_mf_set) else $error("group flag not raised"); // RULE_11

  // Event beats a simultaneous clear or write
  property p_set_wins;
    @(posedge clk_i) disable iff (srst_i)
    evt_i.serial_if |=> s_q.regs[REG_CTRL_ONE][4];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("serial event lost"); // RULE_01

  // Return cycle never doubles as an entry
  property p_return_first;
    @(posedge clk_i) disable iff (srst_i)
    return_from_irq_instr_i |=> !jump_o.push;
  endproperty
  a_return_first: assert property (p_return_first) else $error("entry during return"); // RULE_06

  // Absent global bits stay zero whatever software writes
  property p_global_bits;
    @(posedge clk_i) disable iff (srst_i)
    1'b1 |-> (s_q.regs[REG_GLOBAL] & ~impl_mask(VARIANT, REG_GLOBAL)) == 8'h00;
  endproperty
  a_global_bits: assert property (p_global_bits) else $error("unimplemented bit stored"); // RULE_19

  // Reset leaves every flag and enable clear
  property p_reset_zero;
    @(posedge clk_i)
    srst_i |=> (s_q.regs == '0) && !wake_o && !jump_o.push;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset"); // RULE_24

endmodule

// ===== core/iefc_pkg.sv
package iefc_pkg;

  // Register word indices; byte address is four times the index
  localparam int NREG         = 7;
  localparam int REG_GLOBAL   = 0;
  localparam int REG_CTRL_ONE = 1;
  localparam int REG_CTRL_TWO = 2;
  localparam int REG_CTRL_THR = 3;
  localparam int REG_MF_ZERO  = 4;
  localparam int REG_MF_ONE   = 5;
  localparam int REG_MF_TWO   = 6;
  localparam int REG_STATUS   = 7;
  localparam int IDX_W        = 3;

  // Field positions
  localparam int GLOBAL_EN_BIT = 0;
  localparam int CNT_EVEN_FBIT = 5;
  localparam int CNT_ODD_FBIT  = 7;
  localparam int CNT_EVEN_EBIT = 1;
  localparam int CNT_ODD_EBIT  = 3;
  localparam int STAT_WAKE_BIT = 4;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Vectored sources, listed in ascending vector address (highest priority first)
  localparam int NSRC  = 12;
  localparam int SRC_W = 4;
  localparam int SRC_REG  [NSRC] = '{1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3};
  localparam int SRC_FBIT [NSRC] = '{4, 5, 7, 6, 4, 5, 6, 7, 4, 5, 6, 7};
  localparam int SRC_EBIT [NSRC] = '{0, 1, 3, 2, 0, 1, 2, 3, 0, 1, 2, 3};
  localparam int NMF = 3;

  // Vector layout
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VEC_BASE = 12'h000;
  localparam logic [PC_W-1:0] VEC_STEP = 12'h004;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ENTER  = 2'b01,
    PH_RETURN = 2'b10
  } iefc_phase_e;

  // Peripheral event pulses, one clock each
  typedef struct packed {
    logic       timer_zero;
    logic       timer_one;
    logic       eeprom;
    logic       serial_if;
    logic       timebase;
    logic [5:2] touch;
    logic [5:0] touch_cnt;
  } iefc_evt_s;

  // Requests toward the program sequencer and stack
  typedef struct packed {
    logic            push;
    logic            pop;
    logic            pc_load;
    logic [PC_W-1:0] push_pc;
    logic [PC_W-1:0] pc_addr;
  } iefc_jump_s;

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    iefc_phase_e          phase;
    logic [PC_W-1:0]      push_pc;
    logic [PC_W-1:0]      pc_addr;
    logic [SRC_W-1:0]     last_src;
    logic [31:0]          prdata;
  } iefc_state_s;

  // Implemented bits per register and part variant (0 smallest .. 3 largest)
  function automatic logic [7:0] impl_mask(input int variant, input int r);
    logic [7:0] m;
    m = 8'h00;
    case (r)
      REG_GLOBAL:   m = 8'h01;
      REG_CTRL_ONE: m = 8'hFF;
      REG_CTRL_TWO: m = (variant == 0) ? 8'h11 : ((variant == 1) ? 8'h77 : 8'hFF);
      REG_CTRL_THR: m = (variant == 3) ? 8'hFF : 8'h00;
      REG_MF_ZERO:  m = 8'hFF;
      REG_MF_ONE:   m = (variant == 0) ? 8'h00 : ((variant == 1) ? 8'h33 : 8'hFF);
      REG_MF_TWO:   m = (variant == 3) ? 8'hFF : 8'h00;
      default:      m = 8'h00;
    endcase
    return m;
  endfunction

  function automatic logic [PC_W-1:0] vec_addr(input logic [SRC_W-1:0] idx);
    logic [PC_W-1:0] step_no;
    step_no = PC_W'(idx) + 12'h001;
    return PC_W'(VEC_BASE + PC_W'(VEC_STEP * step_no));
  endfunction

endpackage

// ===== core/iefc_prio_pick.sv
`timescale 1ns/1ps
module iefc_prio_pick
  import iefc_pkg::*;
#(
  parameter int N = 12
)
(
  input  wire logic [N-1:0]         req_i,
  output logic                      any_o,
  output logic [$clog2(N)-1:0]      idx_o
);

  // A single source leaves nothing to arbitrate and a zero-width index
  if (N < 2)
  begin : g_bad_n
    $error("iefc_prio_pick: N must be at least 2");
  end

  // Lowest index wins, so the scan runs from the top down
  always_comb
  begin
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        idx_o = ($clog2(N))'(i);
      end
    end
    any_o = |req_i;
  end

endmodule

// ===== test/iefc_seq_model.sv
`timescale 1ns/1ps
module iefc_seq_model
  import iefc_pkg::*;
#(
  parameter int              DEPTH  = 2,
  parameter logic [PC_W-1:0] PC_RST = 12'h100
)
(
  input  wire logic            clk_i,
  input  wire logic            srst_i,
  input  wire logic            ret_cmd_i,
  input  wire iefc_jump_s      jump_i,
  output logic                 boundary_o,
  output logic [PC_W-1:0]      next_pc_o,
  output logic                 stack_full_o,
  output logic                 return_from_irq_instr_o,
  output logic [PC_W-1:0]      ret_addr_o,
  output logic [PC_W-1:0]      pc_o,
  output int                   depth_o
);
  logic [PC_W-1:0] stk [DEPTH];

  // Program counter stands still unless loaded, so pushed values are predictable
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      depth_o <= 0;
      pc_o    <= PC_RST;
    end
    else
    begin
      if (jump_i.pc_load)
        pc_o <= jump_i.pc_addr;
      if (jump_i.push && depth_o < DEPTH)
      begin
        stk[depth_o] <= jump_i.push_pc;
        depth_o      <= depth_o + 1;
      end
      else if (jump_i.pop && depth_o > 0)
        depth_o <= depth_o - 1;
    end
  end

  // Return only when something is stacked; an empty pop would be a core fault
  assign next_pc_o    = pc_o + 12'h001;
  assign stack_full_o = (depth_o == DEPTH);
  assign boundary_o   = 1'b1;
  assign return_from_irq_instr_o       = ret_cmd_i && (depth_o != 0);
  assign ret_addr_o   = stk[depth_o-1];
endmodule

// ===== test/test_interrupt_enable_flag_controller.sv
`timescale 1ns/1ps
module test_interrupt_enable_flag_controller;
  import iefc_pkg::*;
  localparam logic [7:0] MASK_BIG   [7] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] MASK_SMALL [7] = '{8'h01, 8'hFF, 8'h11, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic            clk_i;
  logic            srst_i;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic            ret_cmd;
  logic            pready;
  logic            perr;
  logic            wake;
  logic            boundary;
  logic            full;
  logic            return_from_irq_instr;
  logic            rerr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic [31:0]     prdata_s;
  logic [7:0]      rdata;
  logic [7:0]      rdata_s;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] pc;
  iefc_evt_s       evt;
  iefc_jump_s      jump;
  int              depth;
  int              n_push = 0;
  int              n_errors = 0;
  int              total_checks = 0;

  iefc_ctrl #(.VARIANT(3)) dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .evt_i(evt), .boundary_i(boundary), .next_pc_i(next_pc), .stack_full_i(full),
    .return_from_irq_instr_i(return_from_irq_instr), .ret_addr_i(ret_addr), .jump_o(jump), .wake_o(wake));
  iefc_ctrl #(.VARIANT(0)) dut_small (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_s), .pready_o(),
    .pslverr_o(), .evt_i(evt), .boundary_i(boundary), .next_pc_i(next_pc), .stack_full_i(full),
    .return_from_irq_instr_i(return_from_irq_instr), .ret_addr_i(ret_addr), .jump_o(), .wake_o());
  iefc_seq_model seq (.clk_i(clk_i), .srst_i(srst_i), .ret_cmd_i(ret_cmd), .jump_i(jump),
    .boundary_o(boundary), .next_pc_o(next_pc), .stack_full_o(full), .return_from_irq_instr_o(return_from_irq_instr),
    .ret_addr_o(ret_addr), .pc_o(pc), .depth_o(depth));

  // Free-running clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Entries seen by the sequencer
  always @(posedge clk_i)
    if (jump.push === 1'b1)
      n_push <= n_push + 1;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input int idx, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= 12'(idx * 4);
    pwdata  <= {24'h00_0000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    rdata   = prdata[7:0];
    rdata_s = prdata_s[7:0];
    rerr    = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input int idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk("register", rdata, e);
  endtask

  task automatic pulse(input iefc_evt_s e);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    @(posedge clk_i);
  endtask

  // Entry has a variable lead time, so poll with a bound
  task automatic wait_push(input int n);
    repeat (20)
    begin
      @(posedge clk_i);
      #1;
      if (n_push == n)
        break;
    end
    @(posedge clk_i);
    chk("pushes", n_push, n);
  endtask

  task automatic ret();
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #50000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    iefc_evt_s e;
    srst_i  = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    evt     = '0;
    ret_cmd = 1'b0;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      rd(i, 8'h00);
      chk("small register", rdata_s, 8'h00);
    end
    apb(1'b0, 8, 8'h00);
    chk("unmapped error", {rerr, rdata}, 9'h100);
    apb(1'b1, 0, 8'hFE);
    rd(0, 8'h00);
    for (int i = 1; i < 7; i++)
      apb(1'b1, i, 8'hFF);
    chk("wake", wake, 1'b1);
    for (int i = 1; i < 7; i++)
    begin
      rd(i, MASK_BIG[i]);
      chk("small register", rdata_s, MASK_SMALL[i]);
      apb(1'b1, i, 8'h00);
    end
    chk("wake", wake, 1'b0);
    chk("pushes", n_push, 0);
    apb(1'b1, 0, 8'h01);
    e = '0;
    e.timer_zero = 1'b1;
    pulse(e);
    repeat (5) @(posedge clk_i);
    rd(1, 8'h80);
    chk("pushes", n_push, 0);
    apb(1'b1, 1, 8'h88);
    wait_push(1);
    chk("vector", pc, 12'h00C);
    chk("depth", depth, 1);
    rd(0, 8'h00);
    rd(1, 8'h08);
    apb(1'b1, 1, 8'h0B);
    e = '0;
    e.eeprom = 1'b1;
    e.serial_if = 1'b1;
    pulse(e);
    rd(1, 8'h3B);
    chk("pushes", n_push, 1);
    apb(1'b1, 0, 8'h01);
    wait_push(2);
    chk("vector", pc, 12'h004);
    rd(1, 8'h2B);
    apb(1'b1, 0, 8'h01);
    repeat (5) @(posedge clk_i);
    chk("pushes", n_push, 2);
    ret();
    wait_push(3);
    chk("vector", pc, 12'h008);
    ret();
    chk("return address", pc, 12'h00E);
    ret();
    chk("return address", pc, 12'h101);
    chk("depth", depth, 0);
    apb(1'b1, 4, 8'h02);
    apb(1'b1, 1, 8'h04);
    apb(1'b1, 0, 8'h01);
    e = '0;
    e.touch_cnt[0] = 1'b1;
    pulse(e);
    wait_push(4);
    chk("vector", pc, 12'h010);
    rd(1, 8'h04);
    rd(4, 8'h22);
    rd(7, 8'h13);
    complete_run();
  end
endmodule
